// *** rtl/tef_frame_processor.sv ***
// Receive frame processor: E1 basic frame search, overhead capture, T1/E1 event flags
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tef_params.svh"
module tef_frame_processor #(
	parameter int RED_CYC = `TEF_RED_MS * `TEF_CLK_KHZ
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire tef_pkg::tef_bus_t     i_bus,
	output logic [7:0]                 o_rd_data,
	input  wire logic                  i_rx_clk,
	input  wire logic                  i_rx_data,
	input  wire tef_pkg::tef_t1_evt_t  i_t1,
	output logic                       o_int,
	output logic                       o_ts16_data,
	output logic                       o_ts16_valid,
	output logic                       o_rx_data,
	output logic                       o_rx_valid
);
	// Refuse a red alarm limit that the counter cannot hold
	generate
		if (RED_CYC < 1 || RED_CYC >= (2 ** `TEF_RED_CW))
		begin : g_bad_red
			$error("RED_CYC does not fit the red alarm counter");
		end
	endgenerate

	localparam logic [`TEF_RED_CW-1:0] RED_LIM = RED_CYC[`TEF_RED_CW-1:0];

	// Registered state and its next value; one struct keeps every flop in one place
	tef_pkg::tef_state_t s;
	tef_pkg::tef_state_t n;

	// Debounce: take the new value once it has been seen 1 or 4 times in a row
	function automatic tef_pkg::tef_deb_t deb(input tef_pkg::tef_deb_t d, input logic x, input logic four);
		tef_pkg::tef_deb_t r;
		r = d;
		if (x == d.v)
			r.c = 2'h0;
		else if (!four || d.c == `TEF_DEB_LAST)
		begin
			r.v = x;
			r.c = 2'h0;
		end
		else
			r.c = 2'(d.c + 2'h1);
		return r;
	endfunction

	always_comb
	begin
		logic              bit_en;
		logic              b;
		logic              e1;
		logic              byp;
		logic              deb4;
		logic [7:0]        pc;
		logic              fp;
		logic [7:0]        w;
		logic [5:0]        csr;
		logic [7:0]        set0;
		logic [7:0]        set1;
		logic [7:0]        sset;
		logic [7:0]        clr0;
		logic [7:0]        clr1;
		logic [7:0]        sclr;
		logic              ivl;
		tef_pkg::tef_fmt_t fmt;
		n = s;
		set0 = 8'h00;
		set1 = 8'h00;
		sset = 8'h00;
		clr0 = 8'h00;
		clr1 = 8'h00;
		sclr = 8'h00;
		ivl = 1'b0;
		pc = 8'h00;
		fp = 1'b0;
		w = 8'h00;
		csr = 6'h00;
		e1 = s.mode1[`TEF_M1_E1];
		byp = s.mode0[`TEF_M0_BYPASS];
		deb4 = s.mode1[`TEF_M1_DEB4];
		fmt = tef_pkg::tef_fmt_t'(s.mode1[`TEF_M1_FMT_HI:`TEF_M1_FMT]);
		bit_en = s.sclk[1] & ~s.clk_d;
		b = s.sdat[1];

		// Line pins pass two flops; the bit is taken on the synchronised rising line clock
		n.sclk = {s.sclk[0], i_rx_clk};
		n.sdat = {s.sdat[0], i_rx_data};
		n.clk_d = s.sclk[1];
		// Strobes last one cycle; the raw bit is passed on even in bypass
		n.ts16_v = 1'b0;
		n.rx_v = bit_en;
		if (bit_en)
			n.rx_d = b;

		// Register writes; flags are write-one-to-clear
		if (i_bus.wr)
		begin
			unique case (i_bus.addr)
				`TEF_OFS_MODE0: n.mode0 = i_bus.wdata;
				`TEF_OFS_MODE1: n.mode1 = i_bus.wdata;
				`TEF_OFS_EN0:   n.en0 = i_bus.wdata;
				`TEF_OFS_EN1:   n.en1 = i_bus.wdata;
				`TEF_OFS_SLCE:  n.sle = i_bus.wdata;
				`TEF_OFS_FLG0:  clr0 = i_bus.wdata;
				`TEF_OFS_FLG1:  clr1 = i_bus.wdata;
				`TEF_OFS_SLCF:  sclr = i_bus.wdata;
				default: ;
			endcase
		end

		// E1 framer walks only on received bits while framing is enabled
		if (bit_en && e1 && !byp)
		begin
			w = {s.win[6:0], b};
			n.win = w;
			pc = 8'(s.pos + 8'h01);
			fp = s.fpar ^ (pc == 8'h00);
			n.pos = pc;
			n.fpar = fp;
			// Counters of the multiframes run on every frame start
			if (pc == 8'h00)
			begin
				n.crc_idx = 4'(s.crc_idx + 4'h1);
				n.smf_cnt = 4'(s.smf_cnt + 4'h1);
			end
			unique case (s.fsm)
				tef_pkg::TEF_HUNT:
				begin
					// The last seven bits form FAS; that bit becomes position 7 of the frame
					if (w[6:0] == `TEF_FAS)
					begin
						n.pos = `TEF_POS_TS0END;
						n.fpar = 1'b0;
						n.fsm = tef_pkg::TEF_NFAS;
					end
				end
				tef_pkg::TEF_NFAS:
				begin
					// A bad NFAS costs one frame before the hunt resumes
					if (pc == `TEF_POS_B2 && fp)
						n.fsm = b ? tef_pkg::TEF_FASC : tef_pkg::TEF_SKIP;
				end
				tef_pkg::TEF_SKIP:
				begin
					// Skip runs to the last bit of the frame after the failed NFAS
					if (pc == `TEF_POS_LAST && !fp)
						n.fsm = tef_pkg::TEF_HUNT;
				end
				tef_pkg::TEF_FASC:
				begin
					// A second FAS two frames on completes the search; a miss hunts at once
					if (pc == `TEF_POS_TS0END && !fp)
					begin
						n.fas_err = 2'h0;
						n.fsm = (w[6:0] == `TEF_FAS) ? tef_pkg::TEF_SYNC : tef_pkg::TEF_HUNT;
					end
				end
				tef_pkg::TEF_SYNC:
				begin
					// In sync: FAS frames are checked, NFAS frames give Si, Sa and alarm bits
					if (pc == `TEF_POS_TS0END && !fp)
					begin
						n.si_fas = w[7];
						if (w[6:0] != `TEF_FAS)
						begin
							set1[`TEF_F1_FER] = 1'b1;
							n.fas_err = 2'(s.fas_err + 2'h1);
							// Three bad FAS in a row drop the frame
							if (s.fas_err == `TEF_LOSS_ERRS)
								n.fsm = tef_pkg::TEF_HUNT;
						end
						else
							n.fas_err = 2'h0;
					end
					if (pc == `TEF_POS_TS0END && fp)
					begin
						n.si_nfas = w[7];
						n.nat = w[4:0];
						n.ra = deb(s.ra, w[5], deb4);
						csr = {s.crc_sr[4:0], w[7]};
						n.crc_sr = csr;
						n.sa_sh = {s.sa_sh[1:0], w[4]};
						// CRC alignment pattern ends in frame 11; a miss there drops it
						if (csr == `TEF_CRC_MFAS)
						begin
							n.crc_idx = `TEF_CRC_F11;
							n.crc_sync = 1'b1;
						end
						else if (s.crc_idx == `TEF_CRC_F11)
							n.crc_sync = 1'b0;
						if (s.crc_idx[2:0] == `TEF_SMF_END)
							n.sacw = {s.sa_sh, w[4]};
					end
					// Timeslot 16 leaves one bit per received bit while aligned
					if (pc >= `TEF_POS_TS16B && pc <= `TEF_POS_TS16E)
					begin
						n.ts16_v = 1'b1;
						n.ts16_d = b;
					end
					// Signaling multiframe starts where the high nibble turns zero
					if (pc == `TEF_POS_TS16E)
					begin
						n.ts16_hi = w[7:4];
						if (w[7:4] == 4'h0 && s.ts16_hi != 4'h0)
						begin
							n.smf_sync = 1'b1;
							n.smf_cnt = 4'h0;
							n.extra = {w[3], w[1], w[0]};
							n.rma = deb(s.rma, w[2], deb4);
						end
						else if (s.smf_cnt == 4'h0)
							n.smf_sync = 1'b0;
					end
					// Interval event at the end of the selected unit
					if (pc == `TEF_POS_LAST)
					begin
						unique case (s.mode1[`TEF_M1_IVS+1:`TEF_M1_IVS])
							2'h0: ivl = 1'b1;
							2'h1: ivl = s.crc_sync && s.crc_idx[2:0] == `TEF_SMF_END;
							2'h2: ivl = s.crc_sync && s.crc_idx == `TEF_MF_END;
							2'h3: ivl = s.smf_sync && s.smf_cnt == `TEF_MF_END;
						endcase
						set1[`TEF_F1_IVL] = ivl;
					end
				end
				default: n.fsm = tef_pkg::TEF_HUNT;
			endcase
		end

		// Software reframe acts on the rising edge of its control bit
		n.refr_d = s.mode0[`TEF_M0_REFR];
		if (s.mode0[`TEF_M0_REFR] && !s.refr_d)
			n.fsm = tef_pkg::TEF_HUNT;
		// Bypass parks the framer; nothing framed, and only the drop of out-of-frame status is flagged
		if (byp || !e1)
			n.fsm = tef_pkg::TEF_HUNT;
		// Multiframe alignment only exists inside basic frame alignment
		if (n.fsm != tef_pkg::TEF_SYNC)
		begin
			n.crc_sync = 1'b0;
			n.smf_sync = 1'b0;
		end

		// Out-of-frame status follows the active framer
		if (byp)
			n.oof_st = 1'b0;
		else if (e1)
			n.oof_st = (n.fsm != tef_pkg::TEF_SYNC);
		else
			n.oof_st = i_t1.oof;
		set0[`TEF_F0_OOF] = n.oof_st ^ s.oof_st;

		// T1 event sources outside E1 and bypass; block and severe errors are also gated by the selected format
		if (!e1 && !byp)
		begin
			set1[`TEF_F1_MFB] = i_t1.mfb;
			set1[`TEF_F1_COFA] = i_t1.cofa;
			set1[`TEF_F1_FER] = i_t1.fer;
			set1[`TEF_F1_BEE] = i_t1.bee && fmt == tef_pkg::TEF_ESF;
			set1[`TEF_F1_SFE] = i_t1.sfe && fmt != tef_pkg::TEF_SLC;
			if (i_t1.slc_valid && fmt == tef_pkg::TEF_SLC)
			begin
				n.slc = i_t1.slc_code;
				// Each code part is compared on its own, so one change raises one flag
				sset[`TEF_SF_CONC] = i_t1.slc_code[`TEF_SLC_C_HI:0] != s.slc[`TEF_SLC_C_HI:0];
				sset[`TEF_SF_MAINT] = i_t1.slc_code[`TEF_SLC_M_HI:`TEF_SLC_M_LO] != s.slc[`TEF_SLC_M_HI:`TEF_SLC_M_LO];
				sset[`TEF_SF_ALARM] = i_t1.slc_code[`TEF_SLC_A_HI:`TEF_SLC_A_LO] != s.slc[`TEF_SLC_A_HI:`TEF_SLC_A_LO];
				sset[`TEF_SF_SWITCH] = i_t1.slc_code[`TEF_SLC_S_HI:`TEF_SLC_S_LO] != s.slc[`TEF_SLC_S_HI:`TEF_SLC_S_LO];
			end
		end

		// Set wins over a clear in the same cycle
		n.f0 = (s.f0 & ~clr0) | set0;
		n.f1 = (s.f1 & ~clr1) | set1;
		n.slf = (s.slf & ~sclr) | sset;
		n.irq = |{s.f0 & s.en0, s.f1 & s.en1, s.slf & s.sle};

		// Counting system clocks keeps the alarm time independent of the line rate
		// Red alarm counter saturates so the alarm holds while OOF lasts
		if (!s.oof_st)
			n.red_cnt = '0;
		else if (s.red_cnt != RED_LIM)
			n.red_cnt = `TEF_RED_CW'(s.red_cnt + 1'b1);
		n.red = s.oof_st && s.red_cnt == RED_LIM;

		// Limitation: the window runs free, so AIS may take up to two windows to show
		// AIS: under three zeros in a 512-bit window
		if (bit_en)
		begin
			n.ais_win = 9'(s.ais_win + 9'h001);
			if (!b && s.zeros != `TEF_AIS_ZEROS)
				n.zeros = 2'(s.zeros + 2'h1);
			if (s.ais_win == `TEF_AIS_WIN)
			begin
				n.ais = (n.zeros != `TEF_AIS_ZEROS);
				n.zeros = 2'h0;
			end
		end

		// Read data valid in the cycle after the strobe only
		n.rd_data = 8'h00;
		if (i_bus.rd)
		begin
			unique case (i_bus.addr)
				`TEF_OFS_MODE0: n.rd_data = s.mode0;
				`TEF_OFS_MODE1: n.rd_data = s.mode1;
				`TEF_OFS_STAT:  n.rd_data = {1'b0, s.crc_sync, s.smf_sync, s.rma.v, s.ra.v, s.ais, s.red, s.oof_st};
				`TEF_OFS_EN0:   n.rd_data = s.en0;
				`TEF_OFS_EN1:   n.rd_data = s.en1;
				`TEF_OFS_FLG0:  n.rd_data = s.f0;
				`TEF_OFS_FLG1:  n.rd_data = s.f1;
				`TEF_OFS_SLC0:  n.rd_data = s.slc[7:0];
				`TEF_OFS_SLC1:  n.rd_data = s.slc[15:8];
				`TEF_OFS_SLC2:  n.rd_data = {4'h0, s.slc[19:16]};
				`TEF_OFS_SLCE:  n.rd_data = s.sle;
				`TEF_OFS_SLCF:  n.rd_data = s.slf;
				`TEF_OFS_SI:    n.rd_data = {6'h00, s.si_nfas, s.si_fas};
				`TEF_OFS_NAT:   n.rd_data = {3'h0, s.nat};
				`TEF_OFS_EXTRA: n.rd_data = {5'h00, s.extra};
				`TEF_OFS_SACW:  n.rd_data = {4'h0, s.sacw};
				default:        n.rd_data = `TEF_RST_BYTE;
			endcase
		end
	end

	// State register; out-of-frame starts declared
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s <= '0;
			s.oof_st <= 1'b1;
		end
		else
			s <= n;
	end

	// Every output is a state flop, so no combinational path reaches a pin
	assign o_rd_data    = s.rd_data;
	assign o_int        = s.irq;
	assign o_ts16_data  = s.ts16_d;
	assign o_ts16_valid = s.ts16_v;
	assign o_rx_data    = s.rx_d;
	assign o_rx_valid   = s.rx_v;
endmodule // tef_frame_processor
`default_nettype wire

// *** rtl/tef_params.svh ***
// Constants for the T1/E1 receive frame processor: offsets, fields, resets, timing
`ifndef TEF_PARAMS_SVH
`define TEF_PARAMS_SVH
`define TEF_AW          8
`define TEF_OFS_MODE0   8'h4d
`define TEF_OFS_MODE1   8'h4e
`define TEF_OFS_STAT    8'h4f
`define TEF_OFS_EN0     8'h50
`define TEF_OFS_EN1     8'h51
`define TEF_OFS_FLG0    8'h52
`define TEF_OFS_FLG1    8'h53
`define TEF_OFS_SLC0    8'h56
`define TEF_OFS_SLC1    8'h57
`define TEF_OFS_SLC2    8'h58
`define TEF_OFS_SLCE    8'h5c
`define TEF_OFS_SLCF    8'h5d
`define TEF_OFS_SI      8'h60
`define TEF_OFS_NAT     8'h61
`define TEF_OFS_EXTRA   8'h62
`define TEF_OFS_SACW    8'h63
`define TEF_M0_BYPASS   0
`define TEF_M0_REFR     1
`define TEF_M1_E1       2
`define TEF_M1_DEB4     3
`define TEF_M1_IVS      4
`define TEF_M1_FMT      0
`define TEF_M1_FMT_HI   1
`define TEF_F0_OOF      0
`define TEF_F1_MFB      0
`define TEF_F1_COFA     1
`define TEF_F1_FER      2
`define TEF_F1_BEE      3
`define TEF_F1_SFE      4
`define TEF_F1_IVL      5
`define TEF_SF_CONC     0
`define TEF_SF_MAINT    1
`define TEF_SF_ALARM    2
`define TEF_SF_SWITCH   3
`define TEF_SLC_C_HI    10
`define TEF_SLC_M_LO    11
`define TEF_SLC_M_HI    13
`define TEF_SLC_A_LO    14
`define TEF_SLC_A_HI    15
`define TEF_SLC_S_LO    16
`define TEF_SLC_S_HI    19
`define TEF_DEB_LAST    2'h3
`define TEF_S_OOF       0
`define TEF_S_RED       1
`define TEF_S_AIS       2
`define TEF_S_RA        3
`define TEF_S_RMA       4
`define TEF_S_SMF       5
`define TEF_S_CRC       6
`define TEF_RST_BYTE    8'h00
`define TEF_FAS         7'h1b
`define TEF_CRC_MFAS    6'h0b
`define TEF_CRC_F11     4'hb
`define TEF_SMF_END     3'h7
`define TEF_MF_END      4'hf
`define TEF_POS_B2      8'h01
`define TEF_POS_TS0END  8'h07
`define TEF_POS_TS16B   8'h80
`define TEF_POS_TS16E   8'h87
`define TEF_POS_LAST    8'hff
`define TEF_LOSS_ERRS   2'h2
`define TEF_AIS_WIN     9'h1ff
`define TEF_AIS_ZEROS   2'h3
`define TEF_CLK_KHZ     250000
`define TEF_RED_MS      100
`define TEF_RED_CW      26
`endif

// *** rtl/tef_pkg.sv ***
// Types of the T1/E1 receive frame processor
`include "tef_params.svh"
package tef_pkg;
	typedef enum logic [1:0] {
		TEF_SF  = 2'b00,
		TEF_ESF = 2'b01,
		TEF_DM  = 2'b10,
		TEF_SLC = 2'b11
	} tef_fmt_t;
	typedef enum logic [2:0] {
		TEF_HUNT = 3'b000,
		TEF_NFAS = 3'b001,
		TEF_SKIP = 3'b010,
		TEF_FASC = 3'b011,
		TEF_SYNC = 3'b100
	} tef_fsm_t;
	typedef struct packed {
		logic                 wr;
		logic                 rd;
		logic [`TEF_AW-1:0]   addr;
		logic [7:0]           wdata;
	} tef_bus_t;
	// SLC code: [10:0] concentrator, [13:11] maintenance, [15:14] alarm, [19:16] switch
	typedef struct packed {
		logic        oof;
		logic        mfb;
		logic        cofa;
		logic        fer;
		logic        bee;
		logic        sfe;
		logic        slc_valid;
		logic [19:0] slc_code;
	} tef_t1_evt_t;
	typedef struct packed {
		logic       v;
		logic [1:0] c;
	} tef_deb_t;
	typedef struct packed {
		logic [1:0]            sclk;
		logic [1:0]            sdat;
		logic                  clk_d;
		tef_fsm_t              fsm;
		logic [7:0]            pos;
		logic                  fpar;
		logic [7:0]            win;
		logic [1:0]            fas_err;
		logic [7:0]            mode0;
		logic [7:0]            mode1;
		logic [7:0]            en0;
		logic [7:0]            en1;
		logic [7:0]            f0;
		logic [7:0]            f1;
		logic [7:0]            sle;
		logic [7:0]            slf;
		logic [19:0]           slc;
		logic                  refr_d;
		logic                  oof_st;
		logic                  red;
		logic [`TEF_RED_CW-1:0] red_cnt;
		logic                  ais;
		logic [8:0]            ais_win;
		logic [1:0]            zeros;
		tef_deb_t              ra;
		tef_deb_t              rma;
		logic                  si_fas;
		logic                  si_nfas;
		logic [4:0]            nat;
		logic [2:0]            extra;
		logic [5:0]            crc_sr;
		logic [3:0]            crc_idx;
		logic                  crc_sync;
		logic [2:0]            sa_sh;
		logic [3:0]            sacw;
		logic [3:0]            ts16_hi;
		logic                  smf_sync;
		logic [3:0]            smf_cnt;
		logic [7:0]            rd_data;
		logic                  irq;
		logic                  ts16_d;
		logic                  ts16_v;
		logic                  rx_d;
		logic                  rx_v;
	} tef_state_t;
endpackage

// *** sim/tb.sv ***
// Self-checking bench for the receive frame processor
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic                 clk = 1'b0;
	logic                 rst_n = 1'b0;
	tef_pkg::tef_bus_t    bus = '0;
	tef_pkg::tef_t1_evt_t t1 = '0;
	logic                 rx_clk;
	logic                 rx_data;
	logic [7:0]           rd_data;
	logic                 irq;
	logic                 ts16_d;
	logic                 ts16_v;
	logic [7:0]           ts_sr = 8'h00;
	logic [7:0]           ts_n = 8'h00;
	logic [7:0]           n0;
	logic [7:0]           fs [5] = '{8'h1b, 8'h1f, 8'h1b, 8'h5f, 8'h1b};
	int                   n_fail = 0;
	int                   tests_run = 0;
	always #2 clk = ~clk;
	tef_frame_processor #(.RED_CYC(200)) tef_frame_processor_i (
		.i_clk       (clk),
		.i_rst_n     (rst_n),
		.i_bus       (bus),
		.o_rd_data   (rd_data),
		.i_rx_clk    (rx_clk),
		.i_rx_data   (rx_data),
		.i_t1        (t1),
		.o_int       (irq),
		.o_ts16_data (ts16_d),
		.o_ts16_valid(ts16_v),
		.o_rx_data   (),
		.o_rx_valid  ()
	);
	tef_line_src tef_line_src_i (
		.i_clk    (clk),
		.o_rx_clk (rx_clk),
		.o_rx_data(rx_data)
	);
	// Collect the serial timeslot 16 stream, first bit ending up on top
	always @(posedge clk)
	begin
		if (ts16_v)
		begin
			ts_sr <= {ts_sr[6:0], ts16_d};
			ts_n <= ts_n + 8'h01;
		end
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Bus cycles; the idle cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	// Read data stand one cycle only, so they are taken mid-cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		bus <= '0;
		@(negedge clk);
		check(rd_data & m, e);
		@(posedge clk);
	endtask
	task automatic chk_int(input logic e);
		@(negedge clk);
		check({7'h00, irq}, {7'h00, e});
		@(posedge clk);
	endtask
	// One-cycle T1 event pulses {boundary, alignment, framing, block, severe, code}
	task automatic pulse(input logic [5:0] p, input logic [19:0] c);
		t1[25:0] <= {p, c};
		@(posedge clk);
		t1[25:20] <= 6'h00;
		@(posedge clk);
	endtask
	// Hang guard
	initial
	begin
		repeat (60000) @(posedge clk);
		n_fail++;
		results();
	end
	// T1 events and codes first, then red alarm, E1 search, remote alarm, reframe and bypass
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(8'h4e, 8'hff, 8'h00);
		rd(8'h51, 8'hff, 8'h00);
		rd(8'h40, 8'hff, 8'h00);
		rd(8'h4f, 8'h01, 8'h00);
		rd(8'h52, 8'h01, 8'h01);
		wr(8'h52, 8'h01);
		rd(8'h52, 8'h01, 8'h00);
		wr(8'h50, 8'h01);
		t1.oof <= 1'b1;
		@(posedge clk);
		rd(8'h4f, 8'h01, 8'h01);
		rd(8'h52, 8'h01, 8'h01);
		chk_int(1'b1);
		wr(8'h52, 8'h01);
		for (int f = 0; f < 4; f++)
		begin
			wr(8'h4e, 8'(f));
			wr(8'h51, (f == 0) ? 8'h00 : 8'h1f);
			pulse(6'h3e, 20'h0_0000);
			rd(8'h53, 8'h1f, {3'b000, f != 3, f == 1, 3'b111});
			chk_int(f != 0);
			wr(8'h53, 8'h01);
			rd(8'h53, 8'h01, 8'h00);
			wr(8'h53, 8'hff);
			chk_int(1'b0);
		end
		wr(8'h5c, 8'h0f);
		pulse(6'h01, 20'hf_ffff);
		rd(8'h5d, 8'h0f, 8'h0f);
		rd(8'h56, 8'hff, 8'hff);
		rd(8'h57, 8'hff, 8'hff);
		rd(8'h58, 8'hff, 8'h0f);
		wr(8'h5d, 8'h0f);
		pulse(6'h01, 20'hf_c7ff);
		rd(8'h5d, 8'h0f, 8'h02);
		chk_int(1'b1);
		wr(8'h5d, 8'h0f);
		t1.oof <= 1'b0;
		wr(8'h4e, 8'h04);
		rd(8'h4f, 8'h02, 8'h00);
		repeat (250) @(posedge clk);
		rd(8'h4f, 8'h03, 8'h03);
		wr(8'h52, 8'hff);
		foreach (fs[k])
			tef_line_src_i.send_frame(fs[k], 8'hff);
		rd(8'h4f, 8'h01, 8'h01);
		tef_line_src_i.send_frame(8'h5f, 8'hff);
		tef_line_src_i.send_frame(8'h1b, 8'hff);
		rd(8'h4f, 8'h01, 8'h00);
		rd(8'h52, 8'h01, 8'h01);
		n0 = ts_n;
		// NFAS frame with the remote alarm bit and all Sa bits set
		tef_line_src_i.send_frame(8'h7f, 8'h96);
		check(ts_n - n0, 8'h08);
		check(ts_sr, 8'h96);
		rd(8'h61, 8'h1f, 8'h1f);
		rd(8'h4f, 8'h08, 8'h08);
		rd(8'h53, 8'h3f, 8'h20);
		wr(8'h4d, 8'h02);
		rd(8'h4f, 8'h01, 8'h01);
		wr(8'h4e, 8'h00);
		wr(8'h4d, 8'h01);
		pulse(6'h20, 20'h0_0000);
		rd(8'h53, 8'h01, 8'h00);
		rd(8'h4f, 8'h01, 8'h00);
		results();
	end
endmodule // tb
bind tef_frame_processor tef_fp_monitor tef_fp_monitor_i (
	.i_clk       (i_clk),
	.i_rst_n     (i_rst_n),
	.i_bus       (i_bus),
	.o_rd_data   (o_rd_data),
	.i_rx_clk    (i_rx_clk),
	.i_t1        (i_t1),
	.o_int       (o_int),
	.o_ts16_valid(o_ts16_valid),
	.o_rx_valid  (o_rx_valid)
);
`default_nettype wire

// *** sim/tef_fp_monitor.sv ***
// Port-level assertions for the receive frame processor
`timescale 1ns/10ps
`default_nettype none
`include "tef_params.svh"
module tef_fp_monitor (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	input  wire tef_pkg::tef_bus_t    i_bus,
	input  wire logic [7:0]           o_rd_data,
	input  wire logic                 i_rx_clk,
	input  wire tef_pkg::tef_t1_evt_t i_t1,
	input  wire logic                 o_int,
	input  wire logic                 o_ts16_valid,
	input  wire logic                 o_rx_valid
);
	logic [7:0] m0_r;
	logic [7:0] m1_r;
	logic [7:0] e0_r;
	logic [7:0] e1_r;
	// T1 events count only outside E1 and bypass; a same-cycle write may move an enable
	wire logic  t1_ok = !m1_r[2] && !m0_r[0] && !i_bus.wr;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Shadow of the mode and enable registers, rebuilt from bus writes
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			m0_r <= 8'h00;
			m1_r <= 8'h00;
			e0_r <= 8'h00;
			e1_r <= 8'h00;
		end
		else if (i_bus.wr)
		begin
			if (i_bus.addr == `TEF_OFS_MODE0) m0_r <= i_bus.wdata;
			if (i_bus.addr == `TEF_OFS_MODE1) m1_r <= i_bus.wdata;
			if (i_bus.addr == `TEF_OFS_EN0) e0_r <= i_bus.wdata;
			if (i_bus.addr == `TEF_OFS_EN1) e1_r <= i_bus.wdata;
		end
	end
	// Bus and line path
	a_rd_idle_zero: assert property (!$past(i_bus.rd) |-> o_rd_data == 8'h00)
		else $error("read data without a read");
	a_rx_bit_pass: assert property ($rose(i_rx_clk) |-> ##[1:5] o_rx_valid)
		else $error("line bit not passed on");
	a_ts16_one_cycle: assert property (o_ts16_valid |=> !o_ts16_valid)
		else $error("timeslot 16 strobe too long");
	// Interrupt output against its causes
	a_int_fall_wr: assert property ($fell(o_int) |-> $past(i_bus.wr, 2))
		else $error("interrupt dropped without a write");
	a_oof_int: assert property ($changed(i_t1.oof) && t1_ok && e0_r[0] |-> ##[2:3] o_int)
		else $error("frame loss change gave no interrupt");
	a_mfb_int: assert property (i_t1.mfb && t1_ok && e1_r[0] |-> ##2 o_int)
		else $error("boundary event gave no interrupt");
	a_fer_int: assert property (i_t1.fer && t1_ok && e1_r[2] |-> ##2 o_int)
		else $error("framing error gave no interrupt");
	a_bee_esf_int: assert property (i_t1.bee && t1_ok && e1_r[3] && m1_r[1:0] == 2'b01 |-> ##2 o_int)
		else $error("block error gave no interrupt");
	a_sfe_int: assert property (i_t1.sfe && t1_ok && e1_r[4] && m1_r[1:0] != 2'b11 |-> ##2 o_int)
		else $error("severe error gave no interrupt");
endmodule // tef_fp_monitor
`default_nettype wire

// *** sim/tef_line_src.sv ***
// Line-side model: sends E1 frames bit by bit under a gated line clock
`timescale 1ns/10ps
`default_nettype none
module tef_line_src (
	input  wire logic i_clk,
	output var logic  o_rx_clk,
	output var logic  o_rx_data
);
	initial
	begin
		o_rx_clk = 1'b0;
		o_rx_data = 1'b0;
	end
	// Data settles while the line clock is low; eight system clocks per bit keeps the synchroniser safe
	task automatic send_bit(input logic b);
		o_rx_data <= b;
		repeat (4) @(posedge i_clk);
		o_rx_clk <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_rx_clk <= 1'b0;
	endtask
	// One 256-bit frame: TS0 and TS16 as given, other slots idle ones
	task automatic send_frame(input logic [7:0] ts0, input logic [7:0] ts16);
		for (int i = 0; i < 256; i++)
		begin
			if (i < 8)
				send_bit(ts0[7-i]);
			else if (i >= 128 && i < 136)
				send_bit(ts16[135-i]);
			else
				send_bit(1'b1);
		end
		// Clock stands still between frames; the data line no longer holds the last bit
		o_rx_data <= ~o_rx_data;
		@(posedge i_clk);
	endtask
endmodule // tef_line_src
`default_nettype wire
